// >>> src/rdisd_params.svh
// Offsets, field positions, reset values and timing counts for the speed-detect config bank.
`ifndef RDISD_PARAMS_SVH
`define RDISD_PARAMS_SVH

// ============================================================
// Register port
`define RDISD_ADDR_W          8
`define RDISD_DATA_W          32
`define RDISD_OFS_ISD         8'h80
`define RDISD_OFS_REV         8'h82
`define RDISD_OFS_STATUS      8'hf0
`define RDISD_OFS_CTRL        8'hf4
`define RDISD_RST_ISD         32'h0000_0000
`define RDISD_RST_REV         32'h0000_0000
`define RDISD_MASK_ISD        32'h1800_1fff
`define RDISD_MASK_REV        32'h7fff_ffff

// ============================================================
// Speed-detect word fields
`define RDISD_COAST_EN_BIT    28
`define RDISD_REV_EN_BIT      27
`define RDISD_COAST_MSB       12
`define RDISD_COAST_LSB       9
`define RDISD_BEMF_MSB        8
`define RDISD_BEMF_LSB        6
`define RDISD_HANDOFF_MSB     5
`define RDISD_HANDOFF_LSB     2
`define RDISD_OLCUR_MSB       1
`define RDISD_OLCUR_LSB       0

// ============================================================
// Reverse-drive word fields
`define RDISD_A1_MSB          30
`define RDISD_A1_LSB          27
`define RDISD_A2_MSB          26
`define RDISD_A2_LSB          23
`define RDISD_BRKCUR_MSB      22
`define RDISD_BRKCUR_LSB      20
`define RDISD_KP_MSB          19
`define RDISD_KP_LSB          10
`define RDISD_KI_MSB          9
`define RDISD_KI_LSB          0
`define RDISD_KP_FRAC_BITS    7
`define RDISD_KI_FRAC_BITS    9

// ============================================================
// Control and status fields
`define RDISD_CTRL_START_BIT  0
`define RDISD_CTRL_ABORT_BIT  1
`define RDISD_STAT_BUSY_BIT   0
`define RDISD_STAT_DONE_BIT   1
`define RDISD_STAT_ELAP_MSB   29
`define RDISD_STAT_ELAP_LSB   16

// ============================================================
// Timing
`define RDISD_CLK_HZ          10000000
`define RDISD_TICK_MS         1
`define RDISD_TICK_CYC        ((`RDISD_CLK_HZ / 1000) * `RDISD_TICK_MS)

`endif

// >>> src/rdisd_pkg.sv
// Types shared by the speed-detect and reverse-drive configuration bank.
package rdisd_pkg;

	// ============================================================
	// Configuration words as seen by the motor-control algorithm
	typedef struct packed {
		logic       coast_step_enable;
		logic       reverse_drive_enable;
		logic [3:0] coast_duration_sel;
		logic [2:0] stationary_bemf_level;
		logic [3:0] reverse_handoff_level;
		logic [1:0] reverse_openloop_current_cap;
	} rdisd_isd_cfg_t;

	typedef struct packed {
		logic [3:0] reverse_accel_first_order;
		logic [3:0] reverse_accel_second_order;
		logic [2:0] braking_current_cap;
		logic [9:0] braking_prop_gain;
		logic [9:0] braking_integral_gain;
	} rdisd_rev_cfg_t;

	// ============================================================
	// Field codes translated to physical units
	typedef struct packed {
		logic [13:0] coast_ms;
		logic [10:0] bemf_mv;
		logic [12:0] rev_current_ma;
		logic [19:0] accel1_centi_hz_s;
		logic [19:0] accel2_centi_hz_s2;
		logic [12:0] brake_current_ma;
	} rdisd_phys_t;

	// ============================================================
	// Coast timer states
	typedef enum logic [1:0] {
		RDISD_IDLE  = 2'b00,
		RDISD_COAST = 2'b01,
		RDISD_DONE  = 2'b10
	} rdisd_state_t;

endpackage

// >>> src/rdisd_decode.sv
// Translates configuration field codes into physical units.
module rdisd_decode
	import rdisd_pkg::*;
(
	input  wire rdisd_isd_cfg_t isd_i,  // Speed-detect fields
	input  wire rdisd_rev_cfg_t rev_i,  // Reverse-drive fields
	output rdisd_phys_t         phys_o  // Decoded values
);

	// One table serves both acceleration coefficients; only code 0 differs.
	function automatic logic [19:0] accel_centi(input logic [3:0] code, input logic first);
		case (code)
			4'h0: accel_centi = first ? 20'h00001 : 20'h00000;
			4'h1: accel_centi = 20'h00005;
			4'h2: accel_centi = 20'h00064;
			4'h3: accel_centi = 20'h000fa;
			4'h4: accel_centi = 20'h001f4;
			4'h5: accel_centi = 20'h003e8;
			4'h6: accel_centi = 20'h009c4;
			4'h7: accel_centi = 20'h01388;
			4'h8: accel_centi = 20'h01d4c;
			4'h9: accel_centi = 20'h02710;
			4'ha: accel_centi = 20'h061a8;
			4'hb: accel_centi = 20'h0c350;
			4'hc: accel_centi = 20'h124f8;
			4'hd: accel_centi = 20'h186a0;
			4'he: accel_centi = 20'h7a120;
			default: accel_centi = 20'hf4240;
		endcase
	endfunction

	always_comb begin
		case (isd_i.coast_duration_sel)
			4'h0: phys_o.coast_ms = 14'h000a;
			4'h1: phys_o.coast_ms = 14'h0032;
			4'h2: phys_o.coast_ms = 14'h0064;
			4'h3: phys_o.coast_ms = 14'h00c8;
			4'h4: phys_o.coast_ms = 14'h012c;
			4'h5: phys_o.coast_ms = 14'h0190;
			4'h6: phys_o.coast_ms = 14'h01f4;
			4'h7: phys_o.coast_ms = 14'h02ee;
			4'h8: phys_o.coast_ms = 14'h03e8;
			4'h9: phys_o.coast_ms = 14'h07d0;
			4'ha: phys_o.coast_ms = 14'h0bb8;
			4'hb: phys_o.coast_ms = 14'h0fa0;
			4'hc: phys_o.coast_ms = 14'h1388;
			4'hd: phys_o.coast_ms = 14'h1d4c;
			4'he: phys_o.coast_ms = 14'h2710;
			default: phys_o.coast_ms = 14'h3a98;
		endcase
		case (isd_i.stationary_bemf_level)
			3'h0: phys_o.bemf_mv = 11'h032;
			3'h1: phys_o.bemf_mv = 11'h04b;
			3'h2: phys_o.bemf_mv = 11'h064;
			3'h3: phys_o.bemf_mv = 11'h0fa;
			3'h4: phys_o.bemf_mv = 11'h1f4;
			3'h5: phys_o.bemf_mv = 11'h2ee;
			3'h6: phys_o.bemf_mv = 11'h3e8;
			default: phys_o.bemf_mv = 11'h5dc;
		endcase
		case (isd_i.reverse_openloop_current_cap)
			2'h0: phys_o.rev_current_ma = 13'h05dc;
			2'h1: phys_o.rev_current_ma = 13'h09c4;
			2'h2: phys_o.rev_current_ma = 13'h0dac;
			default: phys_o.rev_current_ma = 13'h1388;
		endcase
		phys_o.accel1_centi_hz_s  = accel_centi(rev_i.reverse_accel_first_order, 1'b1);
		phys_o.accel2_centi_hz_s2 = accel_centi(rev_i.reverse_accel_second_order, 1'b0);
		case (rev_i.braking_current_cap)
			3'h0: phys_o.brake_current_ma = 13'h01f4;
			3'h1: phys_o.brake_current_ma = 13'h03e8;
			3'h2: phys_o.brake_current_ma = 13'h07d0;
			3'h3: phys_o.brake_current_ma = 13'h0bb8;
			3'h4: phys_o.brake_current_ma = 13'h0fa0;
			3'h5: phys_o.brake_current_ma = 13'h1388;
			3'h6: phys_o.brake_current_ma = 13'h1770;
			default: phys_o.brake_current_ma = 13'h1b58;
		endcase
	end

endmodule

// >>> src/rdisd_cfg_bank.sv
// Speed-detect and reverse-drive configuration register bank with coast timer.
//
// Our own choice: the plain strobed port.
`include "rdisd_params.svh"

// Overview of operation
// - The coast duration code in bits 12 to 9 maps 0h..Fh to 10 ms up to 15 s.
// - The stationary back-EMF code in bits 8 to 6 maps 0h..7h to 50 mV up to 1500 mV.
// - The reverse open-loop current code in bits 1 to 0 maps to 1.5, 2.5, 3.5 and 5.0 A.
// - The first-order reverse acceleration code in bits 30 to 27 maps 0.01 to 10000 Hz/s.
// - The second-order reverse acceleration code in bits 26 to 23 maps 0 to 10000 Hz/s2.
// - The active-braking bus current code in bits 22 to 20 maps 0.5 A up to 7 A.
// - The braking proportional gain is bits 19 to 10 as unsigned, scaled by two to the -7.
// - The braking integral gain is bits 9 to 0 as unsigned, scaled by two to the -9.
// - The reverse-drive word sits at 82h, resets to zero, and bit 31 is reserved.
// - Bit 28 of the speed-detect word enables the coast step when one.
// - Bit 27 of the speed-detect word enables reverse drive when one.
module rdisd_cfg_bank
	import rdisd_pkg::*;
#(
	parameter int unsigned TICK_CYC = `RDISD_TICK_CYC  // Clock cycles per coast tick
)(
	input  wire logic                       clk_i,          // 10 MHz clock
	input  wire logic                       srst_i,         // Synchronous reset
	input  wire logic [`RDISD_ADDR_W-1:0]   reg_addr_i,     // Register address
	input  wire logic [`RDISD_DATA_W-1:0]   reg_wdata_i,    // Write data
	input  wire logic                       reg_wr_i,       // Write strobe
	input  wire logic                       reg_rd_i,       // Read strobe
	output logic      [`RDISD_DATA_W-1:0]   reg_rdata_o,    // Read data, cycle after strobe
	input  wire logic                       coast_start_i,  // Start coast step
	input  wire logic                       coast_abort_i,  // Abort coast step
	output logic                            coast_busy_o,   // Coast step running
	output logic                            coast_done_o,   // Coast step finished
	output rdisd_isd_cfg_t                  isd_cfg_o,      // Speed-detect fields
	output rdisd_rev_cfg_t                  rev_cfg_o,      // Reverse-drive fields
	output rdisd_phys_t                     phys_o,         // Decoded physical values
	output logic      [9:0]                 kp_int_o,       // Gain integer part
	output logic      [6:0]                 kp_frac_o,      // Gain fraction part
	output logic      [9:0]                 ki_frac_o       // Integral gain fraction
);

	// ============================================================
	// Address decode
	logic                     wr_isd;
	logic                     wr_rev;
	logic                     wr_stat;
	logic                     wr_ctrl;
	logic                     hit_any;

	assign wr_isd  = reg_wr_i && (reg_addr_i == `RDISD_OFS_ISD);
	assign wr_rev  = reg_wr_i && (reg_addr_i == `RDISD_OFS_REV);
	assign wr_stat = reg_wr_i && (reg_addr_i == `RDISD_OFS_STATUS);
	assign wr_ctrl = reg_wr_i && (reg_addr_i == `RDISD_OFS_CTRL);
	assign hit_any = (reg_addr_i == `RDISD_OFS_ISD) || (reg_addr_i == `RDISD_OFS_REV)
		|| (reg_addr_i == `RDISD_OFS_STATUS) || (reg_addr_i == `RDISD_OFS_CTRL);

	// ============================================================
	// Configuration words
	logic [`RDISD_DATA_W-1:0] isd_r;
	logic [`RDISD_DATA_W-1:0] rev_r;

	// Unimplemented and reserved bits are masked so they always read zero.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			isd_r <= `RDISD_RST_ISD;
		end else if (wr_isd) begin
			isd_r <= reg_wdata_i & `RDISD_MASK_ISD;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rev_r <= `RDISD_RST_REV;
		end else if (wr_rev) begin
			rev_r <= reg_wdata_i & `RDISD_MASK_REV;
		end
	end

	// ============================================================
	// Field extraction
	rdisd_isd_cfg_t isd_f;
	rdisd_rev_cfg_t rev_f;
	rdisd_phys_t    phys_f;

	always_comb begin
		isd_f.coast_step_enable            = isd_r[`RDISD_COAST_EN_BIT];
		isd_f.reverse_drive_enable         = isd_r[`RDISD_REV_EN_BIT];
		isd_f.coast_duration_sel           = isd_r[`RDISD_COAST_MSB:`RDISD_COAST_LSB];
		isd_f.stationary_bemf_level        = isd_r[`RDISD_BEMF_MSB:`RDISD_BEMF_LSB];
		isd_f.reverse_handoff_level        = isd_r[`RDISD_HANDOFF_MSB:`RDISD_HANDOFF_LSB];
		isd_f.reverse_openloop_current_cap = isd_r[`RDISD_OLCUR_MSB:`RDISD_OLCUR_LSB];
		rev_f.reverse_accel_first_order    = rev_r[`RDISD_A1_MSB:`RDISD_A1_LSB];
		rev_f.reverse_accel_second_order   = rev_r[`RDISD_A2_MSB:`RDISD_A2_LSB];
		rev_f.braking_current_cap          = rev_r[`RDISD_BRKCUR_MSB:`RDISD_BRKCUR_LSB];
		rev_f.braking_prop_gain            = rev_r[`RDISD_KP_MSB:`RDISD_KP_LSB];
		rev_f.braking_integral_gain        = rev_r[`RDISD_KI_MSB:`RDISD_KI_LSB];
	end

	rdisd_decode u_decode (
		.isd_i  (isd_f),
		.rev_i  (rev_f),
		.phys_o (phys_f)
	);

	// ============================================================
	// Registered outputs for the algorithm
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			isd_cfg_o <= '0;
			rev_cfg_o <= '0;
		end else begin
			isd_cfg_o <= isd_f;
			rev_cfg_o <= rev_f;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			phys_o <= '0;
		end else begin
			phys_o <= phys_f;
		end
	end

	// Proportional gain split at its binary point (value = code / 2^7); integral gain passed whole (value = code / 2^9).
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			kp_int_o  <= '0;
			kp_frac_o <= '0;
			ki_frac_o <= '0;
		end else begin
			kp_int_o  <= {7'h00, rev_f.braking_prop_gain[9:`RDISD_KP_FRAC_BITS]};
			kp_frac_o <= rev_f.braking_prop_gain[`RDISD_KP_FRAC_BITS-1:0];
			ki_frac_o <= rev_f.braking_integral_gain;
		end
	end

	// ============================================================
	// Millisecond tick divider, running only while coasting
	localparam int unsigned TICK_W = $clog2(TICK_CYC + 1);

	rdisd_state_t        state_r;
	rdisd_state_t        state_nxt;
	logic [TICK_W-1:0]   tick_cnt_r;
	logic                tick;

	assign tick = (state_r == RDISD_COAST) && (tick_cnt_r == TICK_W'(TICK_CYC - 1));

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tick_cnt_r <= '0;
		end else if (state_r != RDISD_COAST || tick) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + TICK_W'(1);
		end
	end

	// ============================================================
	// Coast step sequencer
	logic [13:0] elapsed_r;
	logic [13:0] target_r;
	logic        go;
	logic        stop;

	assign go   = coast_start_i || (wr_ctrl && reg_wdata_i[`RDISD_CTRL_START_BIT]);
	assign stop = coast_abort_i || (wr_ctrl && reg_wdata_i[`RDISD_CTRL_ABORT_BIT]);

	// With the coast step disabled, a start completes at once.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RDISD_IDLE: begin
				if (go && !stop) begin
					state_nxt = isd_f.coast_step_enable ? RDISD_COAST : RDISD_DONE;
				end
			end
			RDISD_COAST: begin
				if (stop) begin
					state_nxt = RDISD_IDLE;
				end else if (tick && (elapsed_r + 14'h0001 >= target_r)) begin
					state_nxt = RDISD_DONE;
				end
			end
			RDISD_DONE: begin
				state_nxt = RDISD_IDLE;
			end
			default: begin
				state_nxt = RDISD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_r <= RDISD_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// The target is latched at start so later writes do not stretch a running step.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			target_r <= '0;
		end else if (state_r == RDISD_IDLE && go) begin
			target_r <= phys_f.coast_ms;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			elapsed_r <= '0;
		end else if (state_r == RDISD_IDLE && go) begin
			elapsed_r <= '0;
		end else if (tick) begin
			elapsed_r <= elapsed_r + 14'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			coast_busy_o <= 1'b0;
			coast_done_o <= 1'b0;
		end else begin
			coast_busy_o <= (state_nxt == RDISD_COAST);
			coast_done_o <= (state_nxt == RDISD_DONE);
		end
	end

	// ============================================================
	// Sticky completion flag; a new completion beats a clear in the same cycle.
	logic done_flag_r;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			done_flag_r <= 1'b0;
		end else if (state_nxt == RDISD_DONE) begin
			done_flag_r <= 1'b1;
		end else if (wr_stat && reg_wdata_i[`RDISD_STAT_DONE_BIT]) begin
			done_flag_r <= 1'b0;
		end
	end

	// ============================================================
	// Read port
	logic [`RDISD_DATA_W-1:0] status_w;
	logic [`RDISD_DATA_W-1:0] rd_mux;

	always_comb begin
		status_w = '0;
		status_w[`RDISD_STAT_BUSY_BIT] = (state_r == RDISD_COAST);
		status_w[`RDISD_STAT_DONE_BIT] = done_flag_r;
		status_w[`RDISD_STAT_ELAP_MSB:`RDISD_STAT_ELAP_LSB] = elapsed_r;
	end

	always_comb begin
		rd_mux = '0;
		case (reg_addr_i)
			`RDISD_OFS_ISD:    rd_mux = isd_r;
			`RDISD_OFS_REV:    rd_mux = rev_r;
			`RDISD_OFS_STATUS: rd_mux = status_w;
			default:           rd_mux = '0;
		endcase
	end

	// Data stand for exactly one cycle after the read strobe, zero otherwise.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i && hit_any) begin
			reg_rdata_o <= rd_mux;
		end else begin
			reg_rdata_o <= '0;
		end
	end

endmodule

// >>> tb/rdisd_cfg_bank_properties.sv
// Port-level property checker for the configuration bank.
`include "rdisd_params.svh"
module rdisd_cfg_bank_properties
	import rdisd_pkg::*;
#(
	parameter int unsigned TICK_CYC = `RDISD_TICK_CYC  // Clock cycles per coast tick
)(
	input  wire logic                     clk_i,          // Clock
	input  wire logic                     srst_i,         // Synchronous reset
	input  wire logic [`RDISD_ADDR_W-1:0] reg_addr_i,     // Register address
	input  wire logic [`RDISD_DATA_W-1:0] reg_wdata_i,    // Write data
	input  wire logic                     reg_wr_i,       // Write strobe
	input  wire logic                     reg_rd_i,       // Read strobe
	input  wire logic [`RDISD_DATA_W-1:0] reg_rdata_o,    // Read data
	input  wire logic                     coast_start_i,  // Coast start
	input  wire logic                     coast_abort_i,  // Coast abort
	input  wire logic                     coast_busy_o,   // Coast running
	input  wire logic                     coast_done_o,   // Coast finished
	input  wire rdisd_isd_cfg_t           isd_cfg_o,      // Speed-detect fields
	input  wire rdisd_rev_cfg_t           rev_cfg_o,      // Reverse-drive fields
	input  wire rdisd_phys_t              phys_o,         // Decoded values
	input  wire logic [9:0]               kp_int_o,       // Gain integer part
	input  wire logic [6:0]               kp_frac_o,      // Gain fraction part
	input  wire logic [9:0]               ki_frac_o       // Integral gain fraction
);
	logic [14:0] isd_w;

	assign isd_w = {reg_wdata_i[28], reg_wdata_i[27], reg_wdata_i[12:0]};

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	// ============================================================
	// Sequences
	sequence s_wr(logic [7:0] a);
		reg_wr_i && (reg_addr_i == a);
	endsequence
	sequence s_rd(logic [7:0] a);
		reg_rd_i && (reg_addr_i == a);
	endsequence
	sequence s_start;
		coast_start_i && !coast_abort_i && !coast_busy_o && !coast_done_o;
	endsequence

	// ============================================================
	// Properties
	// The config outputs copy the words one edge late, so they follow a write by two edges.
	property p_rev_write;
		s_wr(`RDISD_OFS_REV) |-> ##2
			{1'b0, rev_cfg_o} == ($past(reg_wdata_i, 2) & `RDISD_MASK_REV);
	endproperty
	a_rev_write: assert property (p_rev_write) else $error("reverse word not stored");
	property p_isd_write;
		s_wr(`RDISD_OFS_ISD) |-> ##2 isd_cfg_o == $past(isd_w, 2);
	endproperty
	a_isd_write: assert property (p_isd_write) else $error("speed word not stored");
	property p_rev_read;
		s_rd(`RDISD_OFS_REV) |=> reg_rdata_o == {1'b0, rev_cfg_o};
	endproperty
	a_rev_read: assert property (p_rev_read) else $error("reverse readback wrong");
	property p_isd_read;
		s_rd(`RDISD_OFS_ISD) |=> reg_rdata_o == {3'h0, isd_cfg_o[14:13], 14'h0, isd_cfg_o[12:0]};
	endproperty
	a_isd_read: assert property (p_isd_read) else $error("speed readback wrong");
	property p_rdata_idle;
		!reg_rd_i |=> reg_rdata_o == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
	property p_gains;
		kp_int_o == {7'h00, rev_cfg_o.braking_prop_gain[9:7]} &&
			kp_frac_o == rev_cfg_o.braking_prop_gain[6:0] &&
			ki_frac_o == rev_cfg_o.braking_integral_gain;
	endproperty
	a_gains: assert property (p_gains) else $error("gain split wrong");
	property p_coast_off;
		s_start ##0 !isd_cfg_o.coast_step_enable |=> coast_done_o && !coast_busy_o;
	endproperty
	a_coast_off: assert property (p_coast_off) else $error("disabled coast not skipped");
	property p_coast_on;
		s_start ##0 isd_cfg_o.coast_step_enable |=> (coast_busy_o && !coast_done_o)[*8];
	endproperty
	a_coast_on: assert property (p_coast_on) else $error("enabled coast not held");
	property p_done_pulse;
		coast_done_o |=> !coast_done_o;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
	property p_coast_max;
		isd_cfg_o.coast_duration_sel == 4'hf |-> phys_o.coast_ms == 14'h3a98;
	endproperty
	a_coast_max: assert property (p_coast_max) else $error("longest coast wrong");
	property p_cur_max;
		isd_cfg_o.reverse_openloop_current_cap == 2'h3 |-> phys_o.rev_current_ma == 13'h1388;
	endproperty
	a_cur_max: assert property (p_cur_max) else $error("largest reverse current wrong");
endmodule

bind rdisd_cfg_bank rdisd_cfg_bank_properties #(.TICK_CYC(TICK_CYC)) u_props (
	.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.coast_start_i(coast_start_i), .coast_abort_i(coast_abort_i),
	.coast_busy_o(coast_busy_o), .coast_done_o(coast_done_o), .isd_cfg_o(isd_cfg_o),
	.rev_cfg_o(rev_cfg_o), .phys_o(phys_o), .kp_int_o(kp_int_o), .kp_frac_o(kp_frac_o),
	.ki_frac_o(ki_frac_o)
);

// >>> tb/rdisd_cfg_bank_tb_top.sv
// Self-checking testbench for the configuration bank.
module rdisd_cfg_bank_tb_top
	import rdisd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic           clk_i = 1'b0;
	logic           srst_i = 1'b1;
	logic [7:0]     reg_addr_i = 8'h00;
	logic [31:0]    reg_wdata_i = 32'h0;
	logic           reg_wr_i = 1'b0;
	logic           reg_rd_i = 1'b0;
	logic           coast_start_i = 1'b0;
	logic           coast_abort_i = 1'b0;
	logic [31:0]    reg_rdata_o;
	logic           coast_busy_o;
	logic           coast_done_o;
	rdisd_isd_cfg_t isd_cfg_o;
	rdisd_rev_cfg_t rev_cfg_o;
	rdisd_phys_t    phys_o;
	logic [9:0]     kp_int_o;
	logic [6:0]     kp_frac_o;
	logic [9:0]     ki_frac_o;
	int             failures = 0;
	int             cmp_count = 0;
	int coast_tbl[16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 2000, 3000, 4000, 5000,
		7500, 10000, 15000};
	int bemf_tbl[8] = '{50, 75, 100, 250, 500, 750, 1000, 1500};
	int cur_tbl[4] = '{1500, 2500, 3500, 5000};
	int brk_tbl[8] = '{500, 1000, 2000, 3000, 4000, 5000, 6000, 7000};
	int acc_tbl[16] = '{1, 5, 100, 250, 500, 1000, 2500, 5000, 7500, 10000, 25000, 50000,
		75000, 100000, 500000, 1000000};

	// Small tick keeps the 10 ms coast at 40 cycles.
	rdisd_cfg_bank #(.TICK_CYC(4)) u_dut (
		.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.coast_start_i(coast_start_i), .coast_abort_i(coast_abort_i),
		.coast_busy_o(coast_busy_o), .coast_done_o(coast_done_o), .isd_cfg_o(isd_cfg_o),
		.rev_cfg_o(rev_cfg_o), .phys_o(phys_o), .kp_int_o(kp_int_o), .kp_frac_o(kp_frac_o),
		.ki_frac_o(ki_frac_o)
	);

	always #50 clk_i = ~clk_i;

	// ============================================================
	// Bus and compare helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_i);
		// The outputs copy the words one edge late; this idle edge lets them settle first.
		@(posedge clk_i);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk("read data", exp, reg_rdata_o);
		@(posedge clk_i);
	endtask

	task automatic pulse(input bit abort);
		if (abort) coast_abort_i <= 1'b1;
		else coast_start_i <= 1'b1;
		@(posedge clk_i);
		coast_abort_i <= 1'b0;
		coast_start_i <= 1'b0;
		#1;
	endtask

	// ============================================================
	// Scenarios
	task automatic t_reset;
		rdchk(8'h82, 32'h0);
		rdchk(8'h80, 32'h0);
		chk("coast_ms", 32'h0a, phys_o.coast_ms);
		chk("rev_current_ma", 32'h5dc, phys_o.rev_current_ma);
	endtask

	task automatic t_tables;
		for (int i = 0; i < 16; i++) begin
			wr(8'h80, {19'h0, i[3:0], i[2:0], i[3:0], i[1:0]});
			wr(8'h82, {1'b0, i[3:0], i[3:0], i[2:0], 20'h0});
			chk("coast_ms", coast_tbl[i], phys_o.coast_ms);
			chk("bemf_mv", bemf_tbl[i % 8], phys_o.bemf_mv);
			chk("rev_current_ma", cur_tbl[i % 4], phys_o.rev_current_ma);
			chk("accel1", acc_tbl[i], phys_o.accel1_centi_hz_s);
			chk("accel2", (i == 0) ? 0 : acc_tbl[i], phys_o.accel2_centi_hz_s2);
			chk("brake_current_ma", brk_tbl[i % 8], phys_o.brake_current_ma);
			chk("handoff", i, isd_cfg_o.reverse_handoff_level);
		end
	endtask

	task automatic t_fields;
		wr(8'h82, 32'hffff_ffff);
		rdchk(8'h82, 32'h7fff_ffff);
		chk("kp_int", 32'h7, kp_int_o);
		chk("ki_frac", 32'h3ff, ki_frac_o);
		wr(8'h82, 32'h0002_0600);
		chk("kp_int", 32'h1, kp_int_o);
		chk("kp_frac", 32'h01, kp_frac_o);
		chk("ki_frac", 32'h200, ki_frac_o);
		wr(8'h80, 32'hffff_ffff);
		rdchk(8'h80, 32'h1800_1fff);
		chk("coast enable", 32'h1, isd_cfg_o.coast_step_enable);
		chk("reverse enable", 32'h1, isd_cfg_o.reverse_drive_enable);
		wr(8'h84, 32'hdead_beef);
		rdchk(8'h84, 32'h0);
		rdchk(8'h82, 32'h0002_0600);
		rdchk(8'hf4, 32'h0);
		// A reset in mid-run must bring both words back to zero.
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		rdchk(8'h82, 32'h0);
		rdchk(8'h80, 32'h0);
		chk("kp_int after reset", 32'h0, kp_int_o);
	endtask

	task automatic t_coast;
		int n;
		wr(8'h80, 32'h0);
		pulse(1'b0);
		chk("skip done", 32'h1, coast_done_o);
		chk("skip busy", 32'h0, coast_busy_o);
		@(posedge clk_i);
		wr(8'h80, 32'h1000_0000);
		pulse(1'b0);
		chk("coast busy", 32'h1, coast_busy_o);
		n = 0;
		while (coast_done_o !== 1'b1 && n < 200) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk("coast length ok", 32'h1, (n >= 40 && n <= 41));
		@(posedge clk_i);
		// Status: ten elapsed milliseconds and the sticky done bit, then cleared by writing one.
		rdchk(8'hf0, 32'h000a_0002);
		wr(8'hf0, 32'h0000_0002);
		rdchk(8'hf0, 32'h000a_0000);
		wr(8'hf4, 32'h0000_0001);
		chk("register start busy", 32'h1, coast_busy_o);
		wr(8'hf4, 32'h0000_0002);
		chk("register abort busy", 32'h0, coast_busy_o);
		pulse(1'b0);
		repeat (10) @(posedge clk_i);
		pulse(1'b1);
		chk("abort busy", 32'h0, coast_busy_o);
		chk("abort done", 32'h0, coast_done_o);
		@(posedge clk_i);
	endtask

	// ============================================================
	// Sequencing and verdict
	task automatic summarize;
		if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_tables();
		t_fields();
		t_coast();
		summarize();
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		failures++;
		summarize();
	end
endmodule
